// File: hw/mhc_defines.vh
`ifndef MHC_DEFINES_VH
`define MHC_DEFINES_VH
// Clock period in ns
`define MHC_CLK_NS 4
// Pin timing figures, ns
`define MHC_T_STROBE_NS 32
`define MHC_T_CYCLE_NS 45
`define MHC_T_RECOVER_NS 13
`define MHC_T_LATCH_NS 10
`define MHC_T_SETUP_NS 5
// Latest time for read data to turn valid after the strobe starts
`define MHC_T_VALID_NS 30
// Synchroniser stages between the bus pins and the capture
`define MHC_SYNC_DEPTH 3
// Cycle counts: least times round up
`define MHC_C_STROBE ((`MHC_T_STROBE_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
`define MHC_C_CYCLE ((`MHC_T_CYCLE_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
`define MHC_C_RECOVER ((`MHC_T_RECOVER_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
`define MHC_C_LATCH ((`MHC_T_LATCH_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
`define MHC_C_SETUP ((`MHC_T_SETUP_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
`define MHC_C_VALID ((`MHC_T_VALID_NS + `MHC_CLK_NS - 1) / `MHC_CLK_NS)
// Read strobe stretched so the slowest valid data clears the synchroniser
`define MHC_C_READ (`MHC_C_VALID + `MHC_SYNC_DEPTH)
// Register offsets
`define MHC_REG_CTRL 4'h0
`define MHC_REG_ADDR 4'h1
`define MHC_REG_WDATA 4'h2
`define MHC_REG_RDATA 4'h3
`define MHC_REG_STATUS 4'h4
// Control register fields
`define MHC_CTRL_STYLE 0
`define MHC_CTRL_LATCH_POL 1
`define MHC_CTRL_SEL_POL 2
`define MHC_CTRL_RD_POL 3
`define MHC_CTRL_WR_POL 4
`define MHC_CTRL_QUALIFY 5
`define MHC_CTRL_TWO_PHASE 6
`define MHC_CTRL_BYTE_MODE 7
`define MHC_CTRL_HI_FIRST 8
`define MHC_CTRL_RESET 16'h0000
// Command register fields (written to status offset)
`define MHC_CMD_READ 0
`define MHC_CMD_WRITE 1
`define MHC_CMD_ADDR 2
// Status fields
`define MHC_STAT_BUSY 0
`define MHC_STAT_DONE 1
`define MHC_STAT_REFUSED 2
`endif

// File: hw/mhc_ctrl.v
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "mhc_defines.vh"

// Summary of operation
// - Read: read strobe active with select active
// - Direction mode read: transfer strobe, direction read
// - Write: write or transfer strobe with select
// - Direction held at write through write strobe
// - Select changes only outside active strobe
// - After write only read or write follows
// - Read strobe held at least 32 ns
// - Write strobe held at least 32 ns
// - Read strobe starts spaced 45 ns apart
// - Write strobe starts spaced 45 ns apart
// - 13 ns after strobe before address phase
// - 13 ns between consecutive read strobes
// - 13 ns from write strobe to read
// - Each latch pulse lasts at least 10 ns
module mhc_ctrl #(
    parameter CNT_W = 8
) (
    input wire mclk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg low_addr_latch,
    output reg high_addr_latch,
    output reg chip_sel,
    output reg read_dir,
    output reg write_strobe,
    output reg [15:0] ad_out,
    output reg [15:0] ad_oe,
    input wire [15:0] ad_in
);

    // Phases of a bus operation, one-hot
    localparam ST_IDLE = 7'b0000001;
    localparam ST_LATCH = 7'b0000010;
    localparam ST_GAP = 7'b0000100;
    localparam ST_SETUP = 7'b0001000;
    localparam ST_STROBE = 7'b0010000;
    localparam ST_HOLD = 7'b0100000;
    localparam ST_RECOVER = 7'b1000000;

    localparam integer N_STROBE = `MHC_C_STROBE;
    localparam integer N_READ = `MHC_C_READ;
    localparam integer N_CYCLE = `MHC_C_CYCLE;
    localparam integer N_RECOVER = `MHC_C_RECOVER;
    localparam integer N_LATCH = `MHC_C_LATCH;
    localparam integer N_SETUP = `MHC_C_SETUP;
    localparam [CNT_W-1:0] C_STROBE = N_STROBE[CNT_W-1:0];
    localparam [CNT_W-1:0] C_READ = N_READ[CNT_W-1:0];
    localparam [CNT_W-1:0] C_CYCLE = N_CYCLE[CNT_W-1:0];
    localparam [CNT_W-1:0] C_RECOVER = N_RECOVER[CNT_W-1:0];
    localparam [CNT_W-1:0] C_LATCH = N_LATCH[CNT_W-1:0];
    localparam [CNT_W-1:0] C_SETUP = N_SETUP[CNT_W-1:0];

    reg [15:0] ctrl;
    reg [15:0] addr;
    reg [15:0] wdata;
    reg [15:0] rdata;
    reg busy;
    reg done;
    reg refused;
    reg [6:0] state;
    reg [CNT_W-1:0] cnt;
    reg [CNT_W-1:0] since_start;
    reg op_read;
    reg op_addr;
    reg phase_two;
    reg last_write;
    reg [15:0] ad_s1;
    reg [15:0] ad_s2;
    reg [15:0] ad_s3;

    wire style_dir = ctrl[`MHC_CTRL_STYLE];
    wire pol_latch = ctrl[`MHC_CTRL_LATCH_POL];
    wire pol_sel = ctrl[`MHC_CTRL_SEL_POL];
    wire pol_rd = ctrl[`MHC_CTRL_RD_POL];
    wire pol_wr = ctrl[`MHC_CTRL_WR_POL];
    wire qualify = ctrl[`MHC_CTRL_QUALIFY];
    wire two_phase = ctrl[`MHC_CTRL_TWO_PHASE];
    wire byte_mode = ctrl[`MHC_CTRL_BYTE_MODE];
    wire hi_first = ctrl[`MHC_CTRL_HI_FIRST];
    wire cmd_wr = reg_wr && (reg_addr == `MHC_REG_STATUS);
    wire [15:0] data_mask = byte_mode ? 16'h00ff : 16'hffff;

    // Pin level for an asserted or idle logical signal
    function pin_level;
        input active;
        input pol_high;
        begin
            pin_level = active ? pol_high : ~pol_high;
        end
    endfunction

    // Last count step; zero ends too, so a counter left at zero cannot stall
    function cnt_last;
        input [CNT_W-1:0] c;
        begin
            cnt_last = (c[CNT_W-1:1] == {(CNT_W-1){1'b0}});
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Read-data bus synchroniser; only stages two and three are compared
    always @(posedge mclk)
    begin
        ad_s1 <= ad_in;
        ad_s2 <= ad_s1;
        ad_s3 <= ad_s2;
    end

    ////////////////////////////////////////////////////////////////////////
    // Software register port
    always @(posedge mclk)
    begin
        if (rst)
        begin
            ctrl <= `MHC_CTRL_RESET;
            addr <= 16'h0000;
            wdata <= 16'h0000;
            reg_rdata <= 16'h0000;
        end
        else
        begin
            // Config change while busy would glitch pin polarity, so hold it
            if (reg_wr && reg_addr == `MHC_REG_CTRL && !busy)
                ctrl <= reg_wdata;
            else if (reg_wr && reg_addr == `MHC_REG_ADDR && !busy)
                addr <= reg_wdata;
            else if (reg_wr && reg_addr == `MHC_REG_WDATA && !busy)
                wdata <= reg_wdata;
            if (!reg_rd)
                reg_rdata <= 16'h0000;
            else if (reg_addr == `MHC_REG_CTRL)
                reg_rdata <= ctrl;
            else if (reg_addr == `MHC_REG_ADDR)
                reg_rdata <= addr;
            else if (reg_addr == `MHC_REG_WDATA)
                reg_rdata <= wdata;
            else if (reg_addr == `MHC_REG_RDATA)
                reg_rdata <= rdata;
            else if (reg_addr == `MHC_REG_STATUS)
                reg_rdata <= {13'h0000, refused, done, busy};
            else
                reg_rdata <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle engine: address ops latch then gap; read and write ops setup, strobe, hold, then recovery
    always @(posedge mclk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            cnt <= {CNT_W{1'b0}};
            since_start <= {CNT_W{1'b1}};
            busy <= 1'b0;
            done <= 1'b0;
            refused <= 1'b0;
            op_read <= 1'b0;
            op_addr <= 1'b0;
            phase_two <= 1'b0;
            last_write <= 1'b0;
            rdata <= 16'h0000;
            low_addr_latch <= 1'b0;
            high_addr_latch <= 1'b0;
            chip_sel <= 1'b0;
            read_dir <= 1'b0;
            write_strobe <= 1'b0;
            ad_out <= 16'h0000;
            ad_oe <= 16'h0000;
        end
        else
        begin
            if (since_start != {CNT_W{1'b1}})
                since_start <= since_start + 1'b1;
            if (cnt != {CNT_W{1'b0}})
                cnt <= cnt - 1'b1;
            case (state)
                ST_IDLE:
                begin
                    // Idle pins track current polarity
                    low_addr_latch <= pin_level(1'b0, pol_latch);
                    high_addr_latch <= pin_level(1'b0, pol_latch);
                    chip_sel <= pin_level(1'b0, pol_sel);
                    read_dir <= pin_level(1'b0, pol_rd);
                    write_strobe <= pin_level(1'b0, pol_wr);
                    ad_oe <= 16'h0000;
                    if (cmd_wr && reg_wdata[`MHC_CMD_ADDR] && last_write)
                    begin
                        refused <= 1'b1;
                        done <= 1'b0;
                    end
                    else if (cmd_wr && reg_wdata[`MHC_CMD_ADDR])
                    begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        refused <= 1'b0;
                        op_addr <= 1'b1;
                        phase_two <= 1'b0;
                        state <= ST_LATCH;
                        cnt <= C_LATCH;
                        ad_oe <= 16'hffff;
                        // Single phase sends both bytes; two phase one at a time
                        ad_out <= two_phase ? {8'h00, hi_first ? addr[15:8] : addr[7:0]} : addr;
                        if (qualify)
                            chip_sel <= pin_level(1'b1, pol_sel);
                        if (!two_phase || !hi_first)
                            low_addr_latch <= pin_level(1'b1, pol_latch);
                        if (!two_phase || hi_first)
                            high_addr_latch <= pin_level(1'b1, pol_latch);
                    end
                    else if (cmd_wr && (reg_wdata[`MHC_CMD_READ] || reg_wdata[`MHC_CMD_WRITE]))
                    begin
                        busy <= 1'b1;
                        done <= 1'b0;
                        refused <= 1'b0;
                        op_addr <= 1'b0;
                        op_read <= reg_wdata[`MHC_CMD_READ];
                        state <= ST_SETUP;
                        cnt <= C_SETUP;
                        if (style_dir)
                            read_dir <= pin_level(reg_wdata[`MHC_CMD_READ], pol_rd);
                        if (!reg_wdata[`MHC_CMD_READ])
                        begin
                            ad_out <= wdata & data_mask;
                            ad_oe <= data_mask;
                        end
                    end
                end
                ST_LATCH:
                    if (cnt_last(cnt))
                    begin
                        // Pulse held for the least latch width
                        low_addr_latch <= pin_level(1'b0, pol_latch);
                        high_addr_latch <= pin_level(1'b0, pol_latch);
                        state <= ST_GAP;
                        cnt <= C_SETUP;
                    end
                ST_GAP:
                    if (cnt_last(cnt))
                    begin
                        if (two_phase && !phase_two)
                        begin
                            phase_two <= 1'b1;
                            ad_out <= {8'h00, hi_first ? addr[7:0] : addr[15:8]};
                            if (hi_first)
                                low_addr_latch <= pin_level(1'b1, pol_latch);
                            else
                                high_addr_latch <= pin_level(1'b1, pol_latch);
                            state <= ST_LATCH;
                            cnt <= C_LATCH;
                        end
                        else
                        begin
                            chip_sel <= pin_level(1'b0, pol_sel);
                            ad_oe <= 16'h0000;
                            busy <= 1'b0;
                            done <= 1'b1;
                            last_write <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                ST_SETUP:
                    // Wait for direction setup and the full cycle period from last start
                    if (cnt_last(cnt) && since_start >= C_CYCLE)
                    begin
                        // Select rises with the strobe, never inside it
                        chip_sel <= pin_level(1'b1, pol_sel);
                        since_start <= {CNT_W{1'b0}};
                        if (style_dir)
                            write_strobe <= pin_level(1'b1, pol_wr);
                        else if (op_read)
                            read_dir <= pin_level(1'b1, pol_rd);
                        else
                            write_strobe <= pin_level(1'b1, pol_wr);
                        if (op_read)
                            ad_oe <= 16'h0000;
                        state <= ST_STROBE;
                        cnt <= op_read ? C_READ : C_STROBE; // Late read data must pass the synchroniser
                    end
                ST_STROBE:
                    if (cnt_last(cnt))
                    begin
                        // Capture from the agreed later synchroniser stages
                        if (op_read && ad_s2 == ad_s3)
                            rdata <= ad_s3 & data_mask;
                        else if (op_read)
                            rdata <= ad_s2 & data_mask;
                        // Strobe and select drop together; direction held
                        write_strobe <= pin_level(1'b0, pol_wr);
                        if (!style_dir)
                            read_dir <= pin_level(1'b0, pol_rd);
                        chip_sel <= pin_level(1'b0, pol_sel);
                        state <= ST_HOLD;
                        cnt <= C_SETUP;
                    end
                ST_HOLD:
                    if (cnt_last(cnt))
                    begin
                        // Direction and data hold past strobe end
                        read_dir <= pin_level(1'b0, pol_rd);
                        ad_oe <= 16'h0000;
                        state <= ST_RECOVER;
                        cnt <= C_RECOVER;
                    end
                ST_RECOVER:
                    if (cnt_last(cnt))
                    begin
                        // Recovery covers address, read and write follow-ons
                        busy <= 1'b0;
                        done <= 1'b1;
                        last_write <= !op_read;
                        state <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

endmodule // mhc_ctrl

// File: verif/mhc_ctrl_properties.sv
`timescale 1ns/100ps
`include "mhc_defines.vh"
module mhc_ctrl_props (
    input wire mclk,
    input wire rst,
    input wire [3:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire low_addr_latch,
    input wire high_addr_latch,
    input wire chip_sel,
    input wire read_dir,
    input wire write_strobe,
    input wire [15:0] ad_oe
);
    reg [15:0] cfg;
    reg [1:0] age;
    reg [3:0] gap;
    reg last_wr;
    reg ds_q;
    // Active levels follow a shadow of the control register
    wire sel_a = chip_sel == cfg[2];
    wire rd_a = read_dir == cfg[3];
    wire wr_a = write_strobe == cfg[4];
    wire lat = age == 2'h3 && (low_addr_latch == cfg[1] || high_addr_latch == cfg[1]);
    wire ds = age == 2'h3 && (cfg[0] ? wr_a : wr_a || rd_a);
    wire wcyc = cfg[0] ? wr_a && !rd_a : wr_a;
    ////////////////////////////////////////////////////////////////
    // Pins lag a reset or control write, so they are ignored for three edges
    always @(posedge mclk)
    begin
        if (rst)
        begin
            cfg <= `MHC_CTRL_RESET;
            age <= 2'h0;
            gap <= 4'hf;
            last_wr <= 1'b0;
            ds_q <= 1'b0;
        end
        else
        begin
            cfg <= (reg_wr && reg_addr == `MHC_REG_CTRL) ? reg_wdata : cfg;
            age <= (reg_wr && reg_addr == `MHC_REG_CTRL) ? 2'h0 : (age == 2'h3 ? age : age + 2'h1);
            gap <= (ds && !ds_q) ? 4'h0 : (gap == 4'hf ? gap : gap + 4'h1);
            last_wr <= ds ? wcyc : last_wr;
            ds_q <= ds;
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_select_covers_strobe: assert property (ds |-> sel_a)
        else $error("select not active during strobe");
    a_strobe_min_width: assert property ($rose(ds) |-> ds[*8])
        else $error("strobe shorter than 8 cycles");
    a_latch_min_width: assert property ($rose(lat) |-> lat[*3])
        else $error("latch pulse shorter than 3 cycles");
    a_recover_before_latch: assert property ($fell(ds) |-> (!lat)[*4])
        else $error("latch too soon after strobe");
    a_recover_before_strobe: assert property ($fell(ds) |-> (!ds)[*4])
        else $error("strobe too soon after strobe");
    a_strobe_start_spacing: assert property ($rose(ds) |-> gap >= 4'hb)
        else $error("strobe starts closer than 12 cycles");
    a_direction_held: assert property (cfg[0] && ds |-> $stable(read_dir))
        else $error("direction moved during transfer strobe");
    a_no_addr_after_write: assert property (lat |-> !last_wr)
        else $error("address phase right after write");
    a_byte_upper_free: assert property (cfg[7] && ds |-> ad_oe[15:8] == 8'h00)
        else $error("upper byte driven in byte mode");
    cover property ($rose(ds) && wcyc);
    cover property ($rose(ds) && !wcyc);
    cover property ($rose(lat) && cfg[6]);
endmodule // mhc_ctrl_props

// File: verif/mhc_dev_model.sv
`timescale 1ns/100ps
module mhc_dev_model (
    input wire mclk,
    input wire [15:0] cfg,
    input wire [2:0] lag,
    input wire low_addr_latch,
    input wire high_addr_latch,
    input wire chip_sel,
    input wire read_dir,
    input wire write_strobe,
    input wire [15:0] ad_out,
    input wire [15:0] ad_oe,
    output wire [15:0] ad_in
);
    reg [15:0] addr;
    reg [15:0] mem [0:15];
    reg [7:0] rsh = 8'h00;
    reg tgl = 1'b0;
    // Decode pins by the strap levels
    wire sel_a = chip_sel == cfg[2];
    wire rd_a = read_dir == cfg[3];
    wire wr_a = write_strobe == cfg[4];
    wire lo_a = low_addr_latch == cfg[1] && (!cfg[5] || sel_a);
    wire hi_a = high_addr_latch == cfg[1] && (!cfg[5] || sel_a);
    wire rcyc = sel_a && (cfg[0] ? wr_a && rd_a : rd_a);
    wire wcyc = sel_a && (cfg[0] ? wr_a && !rd_a : wr_a);
    wire rv = rcyc && (lag == 3'h0 || rsh[lag - 3'h1]);
    wire [15:0] drv = rv ? (cfg[7] ? 16'h00ff : 16'hffff) : 16'h0000;
    // Undriven lines flip every cycle so a stale value never looks valid
    assign ad_in = (ad_oe & ad_out) | (~ad_oe & drv & mem[addr[3:0]]) | (~ad_oe & ~drv & ({16{tgl}} ^ 16'h5a5a));
    ////////////////////////////////////////////////////////////////
    always @(posedge mclk)
    begin
        tgl <= !tgl;
        rsh <= {rsh[6:0], rcyc};
    end
    // Latch halves in either order, any time after a read
    always @(negedge lo_a)
    begin
        if (cfg[6]) addr[7:0] <= ad_in[7:0];
        else addr <= ad_in;
    end
    always @(negedge hi_a)
    begin
        if (cfg[6]) addr[15:8] <= ad_in[7:0];
    end
    // Write data taken at the trailing edge of the strobe
    always @(negedge wcyc)
    begin
        mem[addr[3:0]] <= cfg[7] ? {mem[addr[3:0]][15:8], ad_in[7:0]} : ad_in;
    end
endmodule // mhc_dev_model

// File: verif/tb_top.sv
`timescale 1ns/100ps
`include "mhc_defines.vh"
`define CHK(a, b) samples_checked++; if ((a) !== (b)) begin num_errors++; $display("mismatch at %0t: %h vs %h", $time, a, b); end
module tb_top;
    reg mclk = 1'b0;
    reg rst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [15:0] cfg = 16'h0000;
    reg [2:0] lag = 3'h0;
    reg [15:0] d, m, w;
    wire [15:0] reg_rdata, ad_out, ad_oe, ad_in;
    wire lo, hi, sel, dir, wstb;
    int num_errors = 0;
    int samples_checked = 0;
    int i;
    reg [15:0] cfgs [0:3] = '{16'h0000, 16'h003f, 16'h0040, 16'h01c1};
    always #2 mclk = ~mclk;
    mhc_ctrl dut_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .low_addr_latch(lo), .high_addr_latch(hi), .chip_sel(sel),
        .read_dir(dir), .write_strobe(wstb), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in));
    mhc_dev_model dev_u (.mclk(mclk), .cfg(cfg), .lag(lag), .low_addr_latch(lo), .high_addr_latch(hi),
        .chip_sel(sel), .read_dir(dir), .write_strobe(wstb), .ad_out(ad_out), .ad_oe(ad_oe), .ad_in(ad_in));
    ////////////////////////////////////////////////////////////////
    task wr(input [3:0] a, input [15:0] v);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, output [15:0] v);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task stop_test;
        $display("errors %0d, checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Issue a command and poll until idle; status stays in d
    task cmd(input [2:0] c);
        int n;
        wr(`MHC_REG_STATUS, {13'h0000, c});
        for (n = 0; n < 100; n++)
        begin
            rd(`MHC_REG_STATUS, d);
            if (d[`MHC_STAT_BUSY] === 1'b0) break;
        end
        if (n == 100)
        begin
            num_errors++;
            $display("mismatch at %0t: command never finished", $time);
            stop_test();
        end
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (3) @(posedge mclk);
        rd(`MHC_REG_CTRL, d);
        `CHK(d, `MHC_CTRL_RESET)
        `CHK(sel, 1'b1)
        wr(4'hf, 16'hffff);
        rd(4'hf, d);
        `CHK(d, 16'h0000)
        rd(`MHC_REG_CTRL, d);
        `CHK(d, `MHC_CTRL_RESET)
        // Every strobe style, polarity, phase order and data width
        for (i = 0; i < 4; i++)
        begin
            wr(`MHC_REG_CTRL, cfgs[i]);
            cfg <= cfgs[i];
            lag <= i[0] ? 3'h7 : 3'h0; // Slow partner: read data valid late in the strobe
            m = cfgs[i][7] ? 16'h00ff : 16'hffff;
            w = {4'hb, i[3:0], 4'h7, ~i[3:0]};
            rd(`MHC_REG_CTRL, d);
            `CHK(d, cfgs[i])
            `CHK(sel, ~cfgs[i][2])
            wr(`MHC_REG_ADDR, {12'h5a3, i[3:0]});
            cmd(3'h4);
            `CHK(dev_u.addr, {12'h5a3, i[3:0]})
            wr(`MHC_REG_WDATA, w);
            cmd(3'h2);
            `CHK(dev_u.mem[i] & m, w & m)
            wr(`MHC_REG_ADDR, 16'h0000);
            cmd(3'h4);
            `CHK(d[`MHC_STAT_REFUSED], 1'b1)
            `CHK(dev_u.addr, {12'h5a3, i[3:0]})
            cmd(3'h1);
            `CHK(d[`MHC_STAT_DONE], 1'b1)
            `CHK(d[`MHC_STAT_REFUSED], 1'b0)
            rd(`MHC_REG_RDATA, d);
            `CHK(d & m, w & m)
            cmd(3'h1);
            rd(`MHC_REG_RDATA, d);
            `CHK(d & m, w & m)
            w = ~w;
            wr(`MHC_REG_WDATA, w);
            cmd(3'h2);
            cmd(3'h1);
            rd(`MHC_REG_RDATA, d);
            `CHK(d & m, w & m)
        end
        stop_test();
    end
endmodule // tb_top
bind mhc_ctrl mhc_ctrl_props chk_u (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .low_addr_latch(low_addr_latch), .high_addr_latch(high_addr_latch), .chip_sel(chip_sel),
    .read_dir(read_dir), .write_strobe(write_strobe), .ad_oe(ad_oe));
